// [rtl/nco_consts.svh]
// Constants for the numerically controlled oscillator
`ifndef NCO_CONSTS_SVH
`define NCO_CONSTS_SVH
`define NCO_ACC_WIDTH 20
`define NCO_INC_WIDTH 16
`define NCO_INC_RESET 16'h0001
`define NCO_INC_LOW_RESET 8'h01
`define NCO_INC_HIGH_RESET 8'h00
`define NCO_ACC_RESET 20'h00000
`define NCO_CKS_FAST 2'h0
`define NCO_CKS_SYS 2'h1
`define NCO_CKS_CELL 2'h2
`define NCO_CKS_PIN 2'h3
`define NCO_LOAD_EDGES 2'h2
`endif

// [rtl/nco_core.sv]
// Numerically controlled oscillator core
// Behaviour
// RULE_01 - Add increment once per input clock period
// RULE_02 - 20-bit accumulator via three byte registers
// RULE_03 - Sum replaces accumulator on input clock edge
// RULE_04 - Addition carry is raw overflow output
// RULE_05 - Each overflow raises interrupt event
// RULE_06 - 16-bit increment in two byte registers
// RULE_07 - Software writes high byte before low
// RULE_08 - Low write loads buffers second edge later
// RULE_09 - Adder uses only buffered increment copy
// RULE_10 - Disabled: increment writes load buffers immediately
// RULE_11 - Increment buffers hidden from software
// RULE_12 - Four selectable input clock sources
// RULE_13 - Overflow rate is fin times inc over 2^n
// RULE_14 - Overflow through stretcher or toggle to outputs
// RULE_15 - Fixed duty mode toggles on every overflow
// RULE_16 - Pulse mode stretches 1 to 128 periods
// RULE_17 - Clock select codes choose the source
// RULE_18 - Polarity bit inverts final output
// RULE_19 - Disabled: accumulator holds, no events
// RULE_20 - Software accumulator writes win over additions
`timescale 1ns/10ps
`default_nettype none
`include "nco_consts.svh"
module nco_core #(
    parameter int ACC_WIDTH = `NCO_ACC_WIDTH,
    parameter int INC_WIDTH = `NCO_INC_WIDTH
) (
    // System
    input wire logic clk,
    input wire logic reset,
    // Clock sources, synchronous levels
    input wire logic internal_fast_oscillator,
    input wire logic logic_cell_one_output,
    input wire logic external_clock_pin,
    // Control bits
    input wire logic oscillator_enable_bit,
    input wire logic output_enable_bit,
    input wire logic output_polarity_bit,
    input wire logic pulse_frequency_mode_bit,
    input wire logic [2:0] pulse_width_select,
    input wire logic [1:0] clock_source_select,
    // Increment byte writes
    input wire logic increment_low_write,
    input wire logic increment_high_write,
    input wire logic [7:0] increment_write_data,
    // Accumulator byte writes
    input wire logic accumulator_low_write,
    input wire logic accumulator_high_write,
    input wire logic accumulator_upper_write,
    input wire logic [7:0] accumulator_write_data,
    // Readback
    output logic [7:0] increment_low_byte,
    output logic [7:0] increment_high_byte,
    output logic [7:0] accumulator_low_byte,
    output logic [7:0] accumulator_high_byte,
    output logic [7:0] accumulator_upper_byte,
    // Outputs
    output logic accumulator_carry_out,
    output logic overflow_interrupt_event,
    output logic oscillator_output,
    output logic oscillator_pin_out,
    output logic oscillator_pin_oe
);
    if (ACC_WIDTH != `NCO_ACC_WIDTH || INC_WIDTH != `NCO_INC_WIDTH) begin : width_check
        $error("nco_core serves a 20-bit accumulator and 16-bit increment only");
    end

    logic [ACC_WIDTH-1:0] acc_reg;
    logic [INC_WIDTH-1:0] inc_buf_reg;
    logic [7:0] inc_low_reg;
    logic [7:0] inc_high_reg;
    logic src_level;
    logic src_prev_reg;
    logic tick;
    logic [ACC_WIDTH:0] sum;
    logic carry_reg;
    logic toggle_reg;
    logic pulse_reg;
    logic [7:0] pulse_cnt_reg;
    logic [7:0] pulse_len;
    logic raw_out;
    logic acc_write;
    logic overflow_hit;
    nco_pkg::nco_load_state_type load_state_reg;

    // Source select
    always_comb begin
        unique case (clock_source_select) // RULE_12 RULE_17
            `NCO_CKS_FAST: src_level = internal_fast_oscillator;
            `NCO_CKS_SYS: src_level = 1'b0;
            `NCO_CKS_CELL: src_level = logic_cell_one_output;
            `NCO_CKS_PIN: src_level = external_clock_pin;
        endcase
    end

    // Edge of selected source; system clock source ticks every cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            src_prev_reg <= 1'b0;
        end else begin
            src_prev_reg <= src_level;
        end
    end

    assign tick = (clock_source_select == `NCO_CKS_SYS) ? 1'b1 : (src_level && !src_prev_reg);
    assign sum = {1'b0, acc_reg} + {{(ACC_WIDTH - INC_WIDTH + 1){1'b0}}, inc_buf_reg}; // RULE_13
    assign acc_write = accumulator_low_write || accumulator_high_write || accumulator_upper_write;
    assign overflow_hit = oscillator_enable_bit && tick && !acc_write && sum[ACC_WIDTH]; // RULE_20

    // Accumulator
    always_ff @(posedge clk) begin
        if (reset) begin
            acc_reg <= `NCO_ACC_RESET;
        end else if (acc_write) begin
            if (accumulator_low_write) begin // RULE_20
                acc_reg[7:0] <= accumulator_write_data;
            end
            if (accumulator_high_write) begin
                acc_reg[15:8] <= accumulator_write_data;
            end
            if (accumulator_upper_write) begin
                acc_reg[19:16] <= accumulator_write_data[3:0]; // RULE_02
            end
        end else if (oscillator_enable_bit && tick) begin // RULE_19
            acc_reg <= sum[ACC_WIDTH-1:0]; // RULE_01 RULE_03
        end
    end

    // Increment byte registers
    always_ff @(posedge clk) begin
        if (reset) begin
            inc_low_reg <= `NCO_INC_LOW_RESET;
            inc_high_reg <= `NCO_INC_HIGH_RESET;
        end else begin
            if (increment_low_write) begin // RULE_06
                inc_low_reg <= increment_write_data;
            end
            if (increment_high_write) begin
                inc_high_reg <= increment_write_data;
            end
        end
    end

    // Buffer load sequencing
    always_ff @(posedge clk) begin
        if (reset) begin
            load_state_reg <= nco_pkg::NCO_LOAD_IDLE;
            inc_buf_reg <= `NCO_INC_RESET;
        end else if (!oscillator_enable_bit) begin
            load_state_reg <= nco_pkg::NCO_LOAD_IDLE;
            if (increment_low_write) begin // RULE_10
                inc_buf_reg <= {inc_high_reg, increment_write_data};
            end else if (increment_high_write) begin
                inc_buf_reg <= {increment_write_data, inc_low_reg};
            end else begin
                inc_buf_reg <= {inc_high_reg, inc_low_reg};
            end
        end else if (increment_low_write) begin // RULE_08
            load_state_reg <= nco_pkg::NCO_LOAD_WAIT1;
        end else begin
            unique case (load_state_reg)
                nco_pkg::NCO_LOAD_IDLE: load_state_reg <= nco_pkg::NCO_LOAD_IDLE;
                nco_pkg::NCO_LOAD_WAIT1: begin
                    if (tick) begin
                        load_state_reg <= nco_pkg::NCO_LOAD_WAIT2;
                    end
                end
                nco_pkg::NCO_LOAD_WAIT2: begin
                    if (tick) begin
                        load_state_reg <= nco_pkg::NCO_LOAD_IDLE;
                        inc_buf_reg <= {inc_high_reg, inc_low_reg}; // RULE_09
                    end
                end
            endcase
        end
    end

    // Overflow and interrupt
    always_ff @(posedge clk) begin
        if (reset) begin
            carry_reg <= 1'b0;
            overflow_interrupt_event <= 1'b0;
        end else begin
            carry_reg <= overflow_hit; // RULE_04
            overflow_interrupt_event <= overflow_hit; // RULE_05
        end
    end

    always_comb begin
        unique case (pulse_width_select) // RULE_16
            3'h0: pulse_len = 8'h01;
            3'h1: pulse_len = 8'h02;
            3'h2: pulse_len = 8'h04;
            3'h3: pulse_len = 8'h08;
            3'h4: pulse_len = 8'h10;
            3'h5: pulse_len = 8'h20;
            3'h6: pulse_len = 8'h40;
            3'h7: pulse_len = 8'h80;
        endcase
    end

    // Toggle stage
    always_ff @(posedge clk) begin
        if (reset) begin
            toggle_reg <= 1'b0;
        end else if (carry_reg && !pulse_frequency_mode_bit) begin
            toggle_reg <= !toggle_reg; // RULE_15
        end
    end

    // Pulse stretcher, counted in input clock periods
    always_ff @(posedge clk) begin
        if (reset) begin
            pulse_reg <= 1'b0;
            pulse_cnt_reg <= 8'h00;
        end else if (!oscillator_enable_bit || !pulse_frequency_mode_bit) begin
            pulse_reg <= 1'b0;
            pulse_cnt_reg <= 8'h00;
        end else if (carry_reg) begin
            pulse_reg <= 1'b1; // RULE_16
            pulse_cnt_reg <= pulse_len - 8'h01;
        end else if (tick && pulse_reg) begin
            if (pulse_cnt_reg == 8'h00) begin
                pulse_reg <= 1'b0;
            end else begin
                pulse_cnt_reg <= pulse_cnt_reg - 8'h01;
            end
        end
    end

    assign raw_out = (pulse_frequency_mode_bit ? pulse_reg : toggle_reg)
                     ^ output_polarity_bit; // RULE_14 RULE_18

    // Output stage and readback
    always_ff @(posedge clk) begin
        if (reset) begin
            oscillator_output <= 1'b0;
            oscillator_pin_out <= 1'b0;
            oscillator_pin_oe <= 1'b0;
            accumulator_carry_out <= 1'b0;
        end else begin
            oscillator_output <= raw_out;
            oscillator_pin_out <= raw_out;
            oscillator_pin_oe <= output_enable_bit;
            accumulator_carry_out <= carry_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            increment_low_byte <= `NCO_INC_LOW_RESET;
            increment_high_byte <= `NCO_INC_HIGH_RESET;
            accumulator_low_byte <= 8'h00;
            accumulator_high_byte <= 8'h00;
            accumulator_upper_byte <= 8'h00;
        end else begin
            increment_low_byte <= inc_low_reg; // RULE_11
            increment_high_byte <= inc_high_reg;
            accumulator_low_byte <= acc_reg[7:0];
            accumulator_high_byte <= acc_reg[15:8];
            accumulator_upper_byte <= {4'h0, acc_reg[19:16]};
        end
    end
endmodule
`default_nettype wire

// [rtl/nco_pkg.sv]
// Types for the numerically controlled oscillator
package nco_pkg;
    typedef enum logic [1:0] {
        NCO_LOAD_IDLE,
        NCO_LOAD_WAIT1,
        NCO_LOAD_WAIT2
    } nco_load_state_type;
endpackage

// [test/nco_core_monitor.sv]
// Assertion checker for the oscillator core
`timescale 1ns/10ps
`default_nettype none
module nco_core_monitor (
    // Clock and controls
    input wire logic clk,
    input wire logic reset,
    input wire logic oscillator_enable_bit,
    input wire logic output_polarity_bit,
    input wire logic pulse_frequency_mode_bit,
    input wire logic output_enable_bit,
    input wire logic [2:0] pulse_width_select,
    input wire logic [1:0] clock_source_select,
    // Observed outputs
    input wire logic [7:0] accumulator_upper_byte,
    input wire logic accumulator_carry_out,
    input wire logic overflow_interrupt_event,
    input wire logic oscillator_output,
    input wire logic oscillator_pin_out,
    input wire logic oscillator_pin_oe
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (reset);
    sequence idle_run; !oscillator_enable_bit [*4]; endsequence
    sequence fixed_hit; accumulator_carry_out && !pulse_frequency_mode_bit; endsequence
    sequence pulse_hit; accumulator_carry_out && pulse_frequency_mode_bit; endsequence
    // Cycles the output has stood active
    logic [8:0] run_cnt_reg;
    always_ff @(posedge clk) begin
        if (reset || oscillator_output == output_polarity_bit) begin
            run_cnt_reg <= 9'h000;
        end else begin
            run_cnt_reg <= run_cnt_reg + 9'h001;
        end
    end
    carry_follows_a: assert property (overflow_interrupt_event |=> accumulator_carry_out)
        else $error("carry missing");
    carry_cause_a: assert property (accumulator_carry_out |-> $past(overflow_interrupt_event))
        else $error("carry without event");
    event_gap_a: assert property (overflow_interrupt_event |=> !overflow_interrupt_event [*8])
        else $error("events too close");
    idle_quiet_a: assert property (idle_run |-> !overflow_interrupt_event && !accumulator_carry_out)
        else $error("event while disabled");
    upper_zero_a: assert property (accumulator_upper_byte[7:4] == 4'h0)
        else $error("upper bits set");
    toggle_on_a: assert property (fixed_hit |=> $changed(oscillator_output))
        else $error("no toggle");
    toggle_only_a: assert property ($changed(oscillator_output) && oscillator_enable_bit
        && !pulse_frequency_mode_bit |-> $past(accumulator_carry_out)) else $error("stray toggle");
    pulse_start_a: assert property (pulse_hit |-> ##[0:3] oscillator_output != output_polarity_bit)
        else $error("no pulse");
    pin_follow_a: assert property (oscillator_pin_oe |-> oscillator_pin_out == oscillator_output)
        else $error("pin differs");
    pin_enable_a: assert property (oscillator_pin_oe == $past(output_enable_bit))
        else $error("pin enable wrong");
    pulse_width_a: assert property (pulse_frequency_mode_bit && clock_source_select == 2'h1
        && $past(oscillator_enable_bit) && $fell(oscillator_output != output_polarity_bit)
        |-> run_cnt_reg == (9'h001 << pulse_width_select)) else $error("pulse width wrong");
endmodule
bind nco_core nco_core_monitor nco_core_monitor_inst (.clk, .reset, .oscillator_enable_bit,
    .output_polarity_bit, .pulse_frequency_mode_bit, .output_enable_bit,
    .pulse_width_select, .clock_source_select, .accumulator_upper_byte,
    .accumulator_carry_out, .overflow_interrupt_event, .oscillator_output,
    .oscillator_pin_out, .oscillator_pin_oe);
`default_nettype wire

// [test/nco_core_tb.sv]
// Self-checking bench for the oscillator core
`timescale 1ns/10ps
`default_nettype none
module nco_core_tb;
    logic clk, reset, en, oe, pol, pfm, tog, carry, irq, out, pout, poe;
    logic [2:0] src, pws;
    logic [1:0] cks;
    logic [4:0] ws;
    logic [7:0] wd, il, ih, al, ah, au, cc, ic, ovf;
    logic [58:0] q[$];
    logic [31:0] seed, t;
    logic [63:0] tot;
    logic [19:0] acc;
    logic [15:0] inc;
    int err_total, compares, ticks, n, k;
    event take;
    nco_core nco_core_inst (
        .clk(clk), .reset(reset), .internal_fast_oscillator(src[0]),
        .logic_cell_one_output(src[1]), .external_clock_pin(src[2]),
        .oscillator_enable_bit(en), .output_enable_bit(oe), .output_polarity_bit(pol),
        .pulse_frequency_mode_bit(pfm), .pulse_width_select(pws), .clock_source_select(cks),
        .increment_low_write(ws[0]), .increment_high_write(ws[1]), .increment_write_data(wd),
        .accumulator_low_write(ws[2]), .accumulator_high_write(ws[3]),
        .accumulator_upper_write(ws[4]), .accumulator_write_data(wd),
        .increment_low_byte(il), .increment_high_byte(ih), .accumulator_low_byte(al),
        .accumulator_high_byte(ah), .accumulator_upper_byte(au), .accumulator_carry_out(carry),
        .overflow_interrupt_event(irq), .oscillator_output(out), .oscillator_pin_out(pout),
        .oscillator_pin_oe(poe)
    );
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cc <= reset ? 8'h00 : cc + {7'h00, carry};
        ic <= reset ? 8'h00 : ic + {7'h00, irq};
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [4:0] s, input logic [7:0] d);
        ws = s;
        wd = d;
        step();
        ws = 5'h00;
        step();
    endtask
    task automatic note(input logic [58:0] e);
        q.push_back(e);
        -> take;
    endtask
    task automatic compare(input logic [58:0] s, e);
        compares++;
        if (s !== e) begin
            err_total++;
            $display("ERROR at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic conclude();
        $display("Compares %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial forever begin
        @(take);
        compare({poe, pout, out, cc, ic, au, ah, al, ih, il}, q.pop_front());
    end
    initial begin
        #100000;
        err_total++;
        conclude();
    end
    initial begin
        seed = 32'hDDB4;
        {en, oe, pol, pfm, tog, src, pws, cks, ws, wd, ovf} = '0;
        reset = 1'b1;
        repeat (12) @(posedge clk);
        #1 reset = 1'b0;
        step();
        note({43'h0, 16'h0001});
        for (int r = 0; r < 5; r++) begin
            t = rnd();
            {pws, oe, pol} = {1'b0, t[3:0]};
            pfm = (r == 4);
            cks = (r == 4) ? 2'h1 : r[1:0];
            k = (cks == 2'h0) ? 0 : cks - 1;
            inc = t[31:16];
            t = rnd();
            acc = t[19:0];
            wr(5'h02, inc[15:8]);
            wr(5'h01, inc[7:0]);
            wr(5'h10, {4'h0, acc[19:16]});
            wr(5'h08, acc[15:8]);
            wr(5'h04, acc[7:0]);
            step();
            note({oe, {2{pfm ? pol : tog ^ pol}}, ovf, ovf, 4'h0, acc, inc});
            en = 1'b1;
            ticks = 0;
            n = 100 + r * 50;
            for (int i = 0; i < n; i++) begin
                t = (i < 2 || i > n - 5) ? 32'h0 : rnd();
                if (cks == 2'h1 || (t[k] && !src[k])) ticks++;
                src = t[2:0];
                step();
            end
            en = 1'b0;
            tot = acc + inc * ticks;
            ovf = ovf + tot[27:20];
            acc = tot[19:0];
            tog = tog ^ (tot[20] & !pfm);
            repeat (6) step();
            note({oe, {2{pfm ? pol : tog ^ pol}}, ovf, ovf, 4'h0, acc, inc});
            $display("Round %0d done after %0d ticks", r, ticks);
        end
        // Reload while running: old increment for five ticks, new one after
        repeat (3) step();
        t = rnd();
        en = 1'b1;
        wr(5'h02, t[15:8]);
        wr(5'h01, t[7:0]);
        repeat (20) step();
        en = 1'b0;
        tot = acc + inc * 5 + t[15:0] * 19;
        ovf = ovf + tot[27:20];
        acc = tot[19:0];
        inc = t[15:0];
        repeat (6) step();
        note({oe, {2{pol}}, ovf, ovf, 4'h0, acc, inc});
        $display("Reload check done");
        step();
        conclude();
    end
endmodule
`default_nettype wire
